// file: sts_defs.vh
`ifndef STS_DEFS_VH
`define STS_DEFS_VH

// time base: clock period and one millisecond in ns, one millisecond in clock cycles
`define STS_CLK_NS 8
`define STS_MS_NS 1000000
`define STS_MS_CYC 17'h1_E848
`define STS_MS_LAST 10'h3E7
`define STS_CYC_ONE 17'h0_0001

// millisecond arithmetic on the 48-bit time value
`define STS_MS_PER_S48 48'h0000_0000_03E8
`define STS_MIN_MS48 48'h0000_0000_EA60
`define STS_HALF_MIN48 48'h0000_0000_7530
`define STS_TICK1 48'h0000_0000_0001
`define STS_TICK2 48'h0000_0000_0002
`define STS_MIN_MS49 49'h0_0000_0000_EA60
`define STS_HOUR_MS49 49'h0_0000_0036_EE80
`define STS_ZERO49 49'h0_0000_0000_0000
`define STS_STEP_MS49 49'h0_0000_0000_0FA0
`define STS_LDEV_MAX49 49'h0_0000_0000_7FFF
`define STS_FDEV_MAX49 49'h0_0000_0000_007D

// no sync within this many seconds falls back to internal
`define STS_TIMEOUT_S 7'h5A
`define STS_TO_ONE 7'h01

// auto-adjust interval limit, seconds
`define STS_AA_MAX 16'h2710
`define STS_AA_MAX32 32'h0000_2710
`define STS_AA_ONE 16'h0001
`define STS_AA_CNT_ONE 14'h0001

// write limits: offset in ms, zone in minutes
`define STS_OFS_MAX32 32'h0098_9680
`define STS_ZONE_MIN32 32'hFFFF_FD30
`define STS_ZONE_MAX32 32'h0000_0348

// pending soft-correction counters and the message count
`define STS_PEND_ONE 8'h01
`define STS_PEND_ZERO 8'h00
`define STS_CNT_ONE 16'h0001

// sync source codes
`define STS_SRC_INT 4'h0
`define STS_SRC_DI 4'h1
`define STS_SRC_NTP 4'h2

// minute pulse input selection
`define STS_SEL_NONE 2'h0
`define STS_SEL_ONE 2'h1
`define STS_SEL_TWO 2'h2

// register byte addresses
`define STS_A_CTRL 8'h00
`define STS_A_AA_INT 8'h04
`define STS_A_ZONE 8'h08
`define STS_A_OFS 8'h0C
`define STS_A_TIME_LO 8'h10
`define STS_A_TIME_HI 8'h14
`define STS_A_STATUS 8'h18
`define STS_A_LDEV 8'h1C
`define STS_A_FDEV 8'h20

// field positions
`define STS_CF_SEL 1:0
`define STS_CB_SUMMER 2
`define STS_CB_LEAD 3
`define STS_SF_SRC 3:0
`define STS_SF_CNT 31:16
`define STS_TF_HI 15:0

// reset values
`define STS_RST_TIME 48'h0000_0000_0000
`define STS_RST_AA 16'h0000
`define STS_RST_ZONE 11'h000
`define STS_RST_OFS 32'h0000_0000
`define STS_RST_WORD 32'h0000_0000

`endif

// file: sts_tick.v
`timescale 1ns/1ns
`default_nettype none
`include "sts_defs.vh"
module sts_tick #(
  parameter [16:0] MS_CYC = `STS_MS_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // strobes
  output reg ms_tick,
  output reg sec_tick
);

  reg [16:0] cyc_reg;
  reg [9:0] msc_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      cyc_reg <= 17'h0_0000;
      msc_reg <= 10'h000;
      ms_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      sec_tick <= 1'b0;
      if (cyc_reg == MS_CYC - `STS_CYC_ONE) begin
        cyc_reg <= 17'h0_0000;
        ms_tick <= 1'b1;
        if (msc_reg == `STS_MS_LAST) begin
          msc_reg <= 10'h000;
          sec_tick <= 1'b1;
        end else begin
          msc_reg <= msc_reg + 10'h001;
        end
      end else begin
        cyc_reg <= cyc_reg + `STS_CYC_ONE;
      end
    end
  end

endmodule
`default_nettype wire

// file: sts_time_sync.v
// Operation
// RULE_01: internal time stamps events and recordings
// RULE_02: deviation filtered, time steered softly to zero
// RULE_03: learn average drift while externally synchronised
// RULE_04: one ms auto-adjust step per interval
// RULE_05: drift sign picks step direction, lead retards
// RULE_06: sync sets interval and sign, else user
// RULE_07: under four seconds never move time backwards
// RULE_08: select none or one minute-pulse input
// RULE_09: pulse rising edge snaps to nearest minute
// RULE_10: minute pulse held at least 50 ms
// RULE_11: sync input zero delay, leading edge active
// RULE_12: protocol time gets decimal time-zone offset
// RULE_13: summer time adds one hour to NTP
// RULE_14: source indicator shows origin of last sync
// RULE_15: no sync for 1.5 minutes gives internal
// RULE_16: message count increments, wraps at 65535
// RULE_17: latest deviation system minus source, clamped
// RULE_18: filtered deviation is applied correction, clamped
// RULE_19: signed offset compensation added to source
// RULE_20: first-order low-pass filter with clamped output
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "sts_defs.vh"
module sts_time_sync #(
  parameter [16:0] MS_CYC = `STS_MS_CYC
) (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // register port
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WE,
  input wire RE,
  output reg [31:0] RDATA,
  // minute pulse inputs
  input wire INPUT_ONE,
  input wire INPUT_TWO,
  // protocol time message
  input wire PMSG_VALID,
  input wire [3:0] PMSG_SRC,
  input wire [31:0] PMSG_SEC,
  input wire [9:0] PMSG_MS,
  // timestamp request and answer
  input wire STAMP_REQ,
  input wire STAMP_KIND,
  output reg STAMP_VALID,
  output reg STAMP_KIND_Q,
  output reg [47:0] STAMP_TIME,
  // status
  output reg [3:0] SYNC_SOURCE
);

  wire ms_tick;
  wire sec_tick;

  sts_tick #(.MS_CYC(MS_CYC)) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .ms_tick(ms_tick),
    .sec_tick(sec_tick)
  );

  // state
  reg [47:0] time_reg, time_next;
  reg [7:0] slow_reg, slow_next;
  reg [7:0] fast_reg, fast_next;
  reg half_reg, half_next;
  reg [1:0] sel_reg;
  reg summer_reg;
  reg lead_reg, lead_next;
  reg signed [15:0] aa_int_reg, aa_int_next;
  reg [13:0] aa_cnt_reg, aa_cnt_next;
  reg signed [10:0] zone_reg;
  reg signed [31:0] ofs_reg;
  reg [3:0] src_reg, src_next;
  reg [15:0] cnt_reg, cnt_next;
  reg [6:0] to_reg, to_next;
  reg signed [15:0] ldev_reg, ldev_next;
  reg signed [7:0] filt_reg, filt_next;
  reg di_prev_reg;
  reg upd_reg;
  reg signed [48:0] dev_reg;

  // comb helpers
  reg [15:0] aa_mag, m;
  reg lead_l, want_lead;
  reg signed [15:0] f16;
  reg signed [48:0] fsum;

  function signed [15:0] sat;
    input signed [48:0] v;
    input signed [48:0] lim;
    reg signed [48:0] t;
    begin
      t = v;
      if (v > lim)
        t = lim;
      else if (v < -lim)
        t = -lim;
      sat = t[15:0];
    end
  endfunction

  // selected minute pulse and its rising edge
  wire di_sel = (sel_reg == `STS_SEL_ONE) ? INPUT_ONE :
                (sel_reg == `STS_SEL_TWO) ? INPUT_TWO : 1'b0; // see RULE_08
  wire di_edge = di_sel & ~di_prev_reg; // see RULE_09
  wire ev = di_edge | PMSG_VALID;

  // zone limits held at full width so the clamp cuts them on purpose
  wire [31:0] zone_min_w = `STS_ZONE_MIN32;
  wire [31:0] zone_max_w = `STS_ZONE_MAX32;

  // protocol source time in local ms
  wire [47:0] p_base = {16'h0000, PMSG_SEC} * `STS_MS_PER_S48 +
                       {38'h0_0000_0000, PMSG_MS};
  wire signed [48:0] zone_ms =
    $signed({{38{zone_reg[10]}}, zone_reg}) *
    $signed(`STS_MIN_MS49); // see RULE_12
  wire signed [48:0] dst_ms =
    (summer_reg && PMSG_SRC == `STS_SRC_NTP) ?
    $signed(`STS_HOUR_MS49) : $signed(`STS_ZERO49); // see RULE_13
  wire signed [48:0] ofs_ms = $signed({{17{ofs_reg[31]}}, ofs_reg});
  wire signed [48:0] now_s = $signed({1'b0, time_reg});
  wire signed [48:0] src_p = $signed({1'b0, p_base}) + zone_ms + dst_ms;

  // distance to nearest whole minute, positive when leading
  wire [47:0] rem48 = time_reg % `STS_MIN_MS48;
  wire signed [48:0] dev_di = (rem48 >= `STS_HALF_MIN48) ?
    $signed({1'b0, rem48}) - $signed(`STS_MIN_MS49) :
    $signed({1'b0, rem48}); // see RULE_09

  // offset is added to source time, so it is subtracted here
  wire signed [48:0] ev_dev =
    (di_edge ? dev_di : now_s - src_p) - ofs_ms; // see RULE_19
  wire sync_on = (src_reg != `STS_SRC_INT);

  always @* begin
    time_next = time_reg;
    slow_next = slow_reg;
    fast_next = fast_reg;
    half_next = half_reg;
    lead_next = lead_reg;
    aa_int_next = aa_int_reg;
    aa_cnt_next = aa_cnt_reg;
    src_next = src_reg;
    cnt_next = cnt_reg;
    to_next = to_reg;
    ldev_next = ldev_reg;
    filt_next = filt_reg;
    aa_mag = aa_int_reg[15] ? -aa_int_reg : aa_int_reg;
    m = aa_mag;
    lead_l = lead_reg ^ aa_int_reg[15];
    want_lead = 1'b0;
    f16 = 16'h0000;
    fsum = `STS_ZERO49;

    // time base; a slowed clock only pauses, never goes back
    if (ms_tick) begin
      if (fast_reg != `STS_PEND_ZERO) begin
        time_next = time_reg + `STS_TICK2;
        fast_next = fast_reg - `STS_PEND_ONE;
      end else if (slow_reg != `STS_PEND_ZERO) begin
        half_next = ~half_reg; // see RULE_07
        if (half_reg)
          slow_next = slow_reg - `STS_PEND_ONE;
        else
          time_next = time_reg + `STS_TICK1;
      end else begin
        time_next = time_reg + `STS_TICK1; // see RULE_01
      end
    end

    // one ms step per interval, negative interval flips direction
    if (sec_tick) begin
      if (aa_mag == 16'h0000) begin
        aa_cnt_next = 14'h0000;
      end else if ({2'b00, aa_cnt_reg + `STS_AA_CNT_ONE} >= aa_mag) begin
        aa_cnt_next = 14'h0000; // see RULE_04
        if (lead_l)
          slow_next = slow_next + `STS_PEND_ONE; // see RULE_05
        else
          fast_next = fast_next + `STS_PEND_ONE;
      end else begin
        aa_cnt_next = aa_cnt_reg + `STS_AA_CNT_ONE;
      end
      if (sync_on) begin
        if (to_reg + `STS_TO_ONE >= `STS_TIMEOUT_S) begin
          src_next = `STS_SRC_INT; // see RULE_15
          to_next = 7'h00;
        end else begin
          to_next = to_reg + `STS_TO_ONE;
        end
      end
    end

    // new message or pulse
    if (ev) begin
      src_next = di_edge ? `STS_SRC_DI : PMSG_SRC; // see RULE_14
      cnt_next = cnt_reg + `STS_CNT_ONE; // see RULE_16
      to_next = 7'h00;
    end

    // apply the correction one cycle after the event
    if (upd_reg) begin
      ldev_next = sat(dev_reg, $signed(`STS_LDEV_MAX49)); // see RULE_17
      if (dev_reg >= $signed(`STS_STEP_MS49) ||
          dev_reg <= -$signed(`STS_STEP_MS49)) begin
        // a gross error is stepped; small ones never go back
        time_next = time_reg - dev_reg[47:0];
        slow_next = `STS_PEND_ZERO;
        fast_next = `STS_PEND_ZERO;
        f16 = sat(dev_reg, $signed(`STS_FDEV_MAX49));
        filt_next = f16[7:0]; // see RULE_18
      end else begin
        fsum = $signed({{41{filt_reg[7]}}, filt_reg}) +
               ((dev_reg - $signed({{41{filt_reg[7]}}, filt_reg})) >>> 2);
        f16 = sat(fsum, $signed(`STS_FDEV_MAX49)); // see RULE_20
        filt_next = f16[7:0]; // see RULE_18
        // leading is slowed, lagging is sped up
        if (f16 > 16'sh0000) begin
          slow_next = f16[7:0]; // see RULE_02
          fast_next = `STS_PEND_ZERO;
        end else begin
          fast_next = -f16[7:0]; // see RULE_02
          slow_next = `STS_PEND_ZERO;
        end
        // residual error moves the learned step rate
        if (sync_on && f16 != 16'sh0000) begin
          want_lead = (f16 > 16'sh0000); // see RULE_03
          if (m == 16'h0000) begin
            lead_l = want_lead;
            m = `STS_AA_MAX;
          end else if (lead_l == want_lead) begin
            m = m - (m >> 3) - `STS_AA_ONE;
            if (m == 16'h0000)
              m = `STS_AA_ONE;
          end else begin
            m = m + (m >> 3) + `STS_AA_ONE;
            if (m > `STS_AA_MAX)
              m = 16'h0000;
          end
          aa_int_next = m; // see RULE_06
          lead_next = lead_l; // see RULE_06
        end
      end
    end

    // software writes; drift settings are locked while synced
    if (WE) begin
      if (ADDR == `STS_A_TIME_LO) begin
        time_next = {time_reg[47:32], WDATA};
        slow_next = `STS_PEND_ZERO;
        fast_next = `STS_PEND_ZERO;
      end else if (ADDR == `STS_A_TIME_HI) begin
        time_next = {WDATA[`STS_TF_HI], time_reg[31:0]};
      end else if (ADDR == `STS_A_CTRL && !sync_on) begin
        lead_next = WDATA[`STS_CB_LEAD]; // see RULE_06
      end else if (ADDR == `STS_A_AA_INT && !sync_on) begin
        if ($signed(WDATA) > $signed(`STS_AA_MAX32))
          aa_int_next = `STS_AA_MAX;
        else if ($signed(WDATA) < -$signed(`STS_AA_MAX32))
          aa_int_next = -`STS_AA_MAX;
        else
          aa_int_next = WDATA[15:0]; // see RULE_06
        aa_cnt_next = 14'h0000;
      end
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      time_reg <= `STS_RST_TIME;
      slow_reg <= `STS_PEND_ZERO;
      fast_reg <= `STS_PEND_ZERO;
      half_reg <= 1'b0;
      sel_reg <= `STS_SEL_NONE;
      summer_reg <= 1'b0;
      lead_reg <= 1'b0;
      aa_int_reg <= `STS_RST_AA;
      aa_cnt_reg <= 14'h0000;
      zone_reg <= `STS_RST_ZONE;
      ofs_reg <= `STS_RST_OFS;
      src_reg <= `STS_SRC_INT;
      cnt_reg <= 16'h0000;
      to_reg <= 7'h00;
      ldev_reg <= 16'h0000;
      filt_reg <= 8'h00;
      di_prev_reg <= 1'b0;
      upd_reg <= 1'b0;
      dev_reg <= `STS_ZERO49;
      RDATA <= `STS_RST_WORD;
      STAMP_VALID <= 1'b0;
      STAMP_KIND_Q <= 1'b0;
      STAMP_TIME <= `STS_RST_TIME;
      SYNC_SOURCE <= `STS_SRC_INT;
    end else begin
      time_reg <= time_next;
      slow_reg <= slow_next;
      fast_reg <= fast_next;
      half_reg <= half_next;
      lead_reg <= lead_next;
      aa_int_reg <= aa_int_next;
      aa_cnt_reg <= aa_cnt_next;
      src_reg <= src_next;
      cnt_reg <= cnt_next;
      to_reg <= to_next;
      ldev_reg <= ldev_next;
      filt_reg <= filt_next;
      di_prev_reg <= di_sel;
      upd_reg <= ev;
      if (ev)
        dev_reg <= ev_dev;
      SYNC_SOURCE <= src_next;
      // stamp taken from the running time base
      STAMP_VALID <= STAMP_REQ; // see RULE_01
      if (STAMP_REQ) begin
        STAMP_KIND_Q <= STAMP_KIND;
        STAMP_TIME <= time_reg;
      end
      if (WE) begin
        if (ADDR == `STS_A_CTRL) begin
          sel_reg <= WDATA[`STS_CF_SEL]; // see RULE_08
          summer_reg <= WDATA[`STS_CB_SUMMER];
        end else if (ADDR == `STS_A_ZONE) begin
          if ($signed(WDATA) < $signed(`STS_ZONE_MIN32))
            zone_reg <= zone_min_w[10:0];
          else if ($signed(WDATA) > $signed(`STS_ZONE_MAX32))
            zone_reg <= zone_max_w[10:0];
          else
            zone_reg <= WDATA[10:0]; // see RULE_12
        end else if (ADDR == `STS_A_OFS) begin
          if ($signed(WDATA) > $signed(`STS_OFS_MAX32))
            ofs_reg <= `STS_OFS_MAX32;
          else if ($signed(WDATA) < -$signed(`STS_OFS_MAX32))
            ofs_reg <= -`STS_OFS_MAX32;
          else
            ofs_reg <= WDATA; // see RULE_19
        end
      end
      RDATA <= `STS_RST_WORD;
      if (RE) begin
        if (ADDR == `STS_A_CTRL)
          RDATA <= {28'h000_0000, lead_reg, summer_reg, sel_reg};
        else if (ADDR == `STS_A_AA_INT)
          RDATA <= {{16{aa_int_reg[15]}}, aa_int_reg};
        else if (ADDR == `STS_A_ZONE)
          RDATA <= {{21{zone_reg[10]}}, zone_reg};
        else if (ADDR == `STS_A_OFS)
          RDATA <= ofs_reg;
        else if (ADDR == `STS_A_TIME_LO)
          RDATA <= time_reg[31:0];
        else if (ADDR == `STS_A_TIME_HI)
          RDATA <= {16'h0000, time_reg[47:32]};
        else if (ADDR == `STS_A_STATUS)
          RDATA <= {cnt_reg, 12'h000, src_reg};
        else if (ADDR == `STS_A_LDEV)
          RDATA <= {{16{ldev_reg[15]}}, ldev_reg};
        else if (ADDR == `STS_A_FDEV)
          RDATA <= {{24{filt_reg[7]}}, filt_reg};
      end
    end
  end

endmodule
`default_nettype wire

// file: sts_time_sync_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sts_time_sync_chk #(
  parameter [16:0] MS_CYC = 17'h0_0008
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  input wire logic [31:0] RDATA,
  // sync inputs
  input wire logic INPUT_ONE,
  input wire logic INPUT_TWO,
  input wire logic PMSG_VALID,
  input wire logic [3:0] PMSG_SRC,
  // stamps and status
  input wire logic STAMP_REQ,
  input wire logic STAMP_KIND,
  input wire logic STAMP_VALID,
  input wire logic STAMP_KIND_Q,
  input wire logic [47:0] STAMP_TIME,
  input wire logic [3:0] SYNC_SOURCE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  reg [1:0] sel_q;
  reg p1_q;
  reg p2_q;
  reg ev_q;
  reg [31:0] since_q;
  wire pulse_now;
  // select bits are written in every mode, so a plain mirror suffices
  assign pulse_now = (sel_q == 2'h1 && INPUT_ONE && !p1_q) ||
    (sel_q == 2'h2 && INPUT_TWO && !p2_q);
  always @(posedge CLK) begin
    p1_q <= INPUT_ONE;
    p2_q <= INPUT_TWO;
    ev_q <= pulse_now || PMSG_VALID;
    if (!RST_N) begin
      sel_q <= 2'h0;
      since_q <= 32'h0000_0000;
    end else begin
      if (WE && ADDR == 8'h00)
        sel_q <= WDATA[1:0];
      if (pulse_now || PMSG_VALID)
        since_q <= 32'h0000_0000;
      else
        since_q <= since_q + 32'h0000_0001;
    end
  end
  sequence s_stamp_ans;
    STAMP_VALID && STAMP_KIND_Q == $past(STAMP_KIND);
  endsequence
  a_stamp_answer:
  assert property (STAMP_REQ |=> s_stamp_ans)
    else $error("stamp answer missing or wrong kind");
  a_stamp_cause:
  assert property (STAMP_VALID |-> $past(STAMP_REQ))
    else $error("stamp valid without request");
  a_stamp_hold:
  assert property (!STAMP_REQ |=> $stable(STAMP_TIME) && $stable(STAMP_KIND_Q))
    else $error("stamp output changed without request");
  a_read_idle:
  assert property (!$past(RE) |-> RDATA == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_pulse_source:
  assert property (pulse_now |=> SYNC_SOURCE == 4'h1)
    else $error("minute pulse not shown as source");
  a_msg_source:
  assert property (PMSG_VALID && !pulse_now |=> SYNC_SOURCE == $past(PMSG_SRC))
    else $error("message source not shown");
  a_source_cause:
  assert property ($changed(SYNC_SOURCE) && SYNC_SOURCE != 4'h0 |-> ev_q)
    else $error("source changed without sync");
  a_source_timeout:
  assert property ($fell(SYNC_SOURCE != 4'h0) |->
    since_q >= 32'h0001_5BA8 * MS_CYC)
    else $error("source fell back to internal too early");
endmodule
bind sts_time_sync sts_time_sync_chk #(.MS_CYC(MS_CYC)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
  .RE(RE), .RDATA(RDATA), .INPUT_ONE(INPUT_ONE), .INPUT_TWO(INPUT_TWO),
  .PMSG_VALID(PMSG_VALID), .PMSG_SRC(PMSG_SRC), .STAMP_REQ(STAMP_REQ),
  .STAMP_KIND(STAMP_KIND), .STAMP_VALID(STAMP_VALID),
  .STAMP_KIND_Q(STAMP_KIND_Q), .STAMP_TIME(STAMP_TIME),
  .SYNC_SOURCE(SYNC_SOURCE));
`default_nettype wire

// file: sts_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module sts_src_model #(
  parameter [16:0] MS_CYC = 17'h0_0008
) (
  // clock
  input wire logic clk,
  // minute pulse lines
  output logic pulse_one,
  output logic pulse_two,
  // protocol message
  output logic msg_valid,
  output logic [3:0] msg_src,
  output logic [31:0] msg_sec,
  output logic [9:0] msg_ms
);
  localparam int HOLD = 32'h0000_0032 * MS_CYC + 32'h0000_0004;
  initial begin
    pulse_one = 1'b0;
    pulse_two = 1'b0;
    msg_valid = 1'b0;
    msg_src = 4'h0;
    msg_sec = 32'h0000_0000;
    msg_ms = 10'h000;
  end
  // rising edge leads, no delay; held past the minimum with margin
  task pulse(input bit two);
    @(posedge clk);
    if (two)
      pulse_two <= 1'b1;
    else
      pulse_one <= 1'b1;
    repeat (HOLD) @(posedge clk);
    pulse_one <= 1'b0;
    pulse_two <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask
  task msg(input [3:0] s, input [31:0] sec, input [9:0] ms, input int n);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_src <= s;
    msg_sec <= sec;
    msg_ms <= ms;
    repeat (n) @(posedge clk);
    msg_valid <= 1'b0;
    // released fields must not look like a still-valid message
    msg_src <= ~s;
    msg_sec <= ~sec;
    msg_ms <= ~ms;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: sts_time_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sts_defs.vh"
module sts_time_sync_tb;
  localparam [16:0] MSC = 17'h0_0008;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic req = 1'b0;
  logic kind = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, rdv, msec;
  logic in1, in2, mv, sv, kq;
  logic [3:0] ms_src, src;
  logic [9:0] mms;
  logic [47:0] st;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  sts_time_sync #(.MS_CYC(MSC)) dut (.CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re), .RDATA(rdata),
    .INPUT_ONE(in1), .INPUT_TWO(in2), .PMSG_VALID(mv), .PMSG_SRC(ms_src),
    .PMSG_SEC(msec), .PMSG_MS(mms), .STAMP_REQ(req), .STAMP_KIND(kind),
    .STAMP_VALID(sv), .STAMP_KIND_Q(kq), .STAMP_TIME(st),
    .SYNC_SOURCE(src));
  sts_src_model #(.MS_CYC(MSC)) src_m (.clk(clk), .pulse_one(in1),
    .pulse_two(in2), .msg_valid(mv), .msg_src(ms_src), .msg_sec(msec),
    .msg_ms(mms));
  task results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [47:0] g, input [47:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkr(input [47:0] g, input [47:0] lo, input [47:0] hi);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rdv = rdata;
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    rd(a);
    chk({16'h0000, rdv}, {16'h0000, e});
  endtask
  task stp(input logic k, input [47:0] lo, input [47:0] hi);
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    @(posedge clk);
    req <= 1'b0;
    #1 chk({47'h0, sv}, 48'h1);
    chk({47'h0, kq}, {47'h0, k});
    chkr(st, lo, hi);
  endtask
  // ceiling covers the long message burst plus the pulse scenarios
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h0001_7318) begin
      bad_count++;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`STS_A_STATUS, 32'h0000_0000);
    wr(8'h24, 32'h0000_1234);
    rdc(8'h24, 32'h0000_0000);
    wr(`STS_A_AA_INT, 32'h0000_4E20);
    rdc(`STS_A_AA_INT, `STS_AA_MAX32);
    wr(`STS_A_AA_INT, 32'h0000_0000);
    wr(`STS_A_ZONE, 32'h0000_03E8);
    rdc(`STS_A_ZONE, `STS_ZONE_MAX32);
    wr(`STS_A_ZONE, 32'h0000_0159);
    rdc(`STS_A_ZONE, 32'h0000_0159);
    wr(`STS_A_OFS, 32'h0131_2D00);
    rdc(`STS_A_OFS, `STS_OFS_MAX32);
    wr(`STS_A_OFS, 32'h0000_0000);
    wr(`STS_A_TIME_LO, 32'h0000_1234);
    stp(1'b1, 48'h0000_0000_1234, 48'h0000_0000_1235);
    stp(1'b0, 48'h0000_0000_1234, 48'h0000_0000_1236);
    // one second interval, lead: each second holds one ms back
    wr(`STS_A_CTRL, 32'h0000_0008);
    wr(`STS_A_AA_INT, 32'h0000_0001);
    wr(`STS_A_TIME_LO, 32'h0000_1000);
    repeat (32'h0000_3E96) @(posedge clk);
    stp(1'b0, 48'h0000_0000_17CF, 48'h0000_0000_17D1);
    wr(`STS_A_AA_INT, 32'h0000_0000);
    // two second lead: slowed, never stepped back
    wr(`STS_A_CTRL, 32'h0000_0001);
    wr(`STS_A_TIME_LO, 32'h0004_9BB0);
    src_m.pulse(1'b0);
    stp(1'b0, 48'h0000_0004_9BB0, 48'h0000_0004_9BEC);
    rd(`STS_A_LDEV);
    chkr({16'h0000, rdv}, 48'h07D0, 48'h07D1);
    rdc(`STS_A_FDEV, 32'h0000_007D);
    rdc(`STS_A_AA_INT, 32'h0000_2710);
    rdc(`STS_A_CTRL, 32'h0000_0009);
    wr(`STS_A_AA_INT, 32'h0000_0005);
    rdc(`STS_A_AA_INT, 32'h0000_2710);
    src_m.pulse(1'b1);
    // ten second lead is stepped out at once
    wr(`STS_A_TIME_LO, 32'h0004_BAF0);
    src_m.pulse(1'b0);
    stp(1'b0, 48'h0000_0004_93E0, 48'h0000_0004_9450);
    rd(`STS_A_LDEV);
    chkr({16'h0000, rdv}, 48'h2710, 48'h2711);
    // input two selected, one second lag
    wr(`STS_A_CTRL, 32'h0000_0002);
    wr(`STS_A_TIME_LO, 32'h0005_7A58);
    src_m.pulse(1'b1);
    rd(`STS_A_LDEV);
    chkr({32'h0, rdv[15:0]}, 48'hFC18, 48'hFC1A);
    rd(`STS_A_FDEV);
    chk({32'h0, rdv[15:0]}, 48'hFF83);
    rdc(`STS_A_AA_INT, 32'h0000_0000);
    stp(1'b0, 48'h0000_0005_7A58, 48'h0000_0005_7B3E);
    // protocol messages: zone, summer time only for NTP, offset
    wr(`STS_A_ZONE, 32'h0000_003C);
    wr(`STS_A_OFS, 32'h0000_01F4);
    wr(`STS_A_CTRL, 32'h0000_0004);
    wr(`STS_A_TIME_LO, 32'h006E_09EC);
    src_m.msg(`STS_SRC_NTP, 32'h0000_000A, 10'h000, 1);
    rd(`STS_A_LDEV);
    chkr({16'h0000, rdv}, 48'h03E8, 48'h03EA);
    chk({44'h0, src}, 48'h2);
    wr(`STS_A_TIME_LO, 32'h0037_1B6C);
    src_m.msg(4'h5, 32'h0000_000A, 10'h000, 1);
    rd(`STS_A_LDEV);
    chkr({16'h0000, rdv}, 48'h03E8, 48'h03EA);
    rdc(`STS_A_STATUS, 32'h0005_0005);
    src_m.msg(4'h5, 32'h0000_000A, 10'h000, 32'h0001_0000);
    rdc(`STS_A_STATUS, 32'h0005_0005);
    results;
  end
endmodule
`default_nettype wire
